//--- verilog/mex_exec_unit.sv
// Notes on behaviour
// - return pops stack into fetch pointer, no flags
// - return takes two cycles, second one idle
// - halt clears watchdog counter and prescaler
// - halt clears powerdown, sets timeout, nothing else
// - halt enters low-power state, oscillator stopped
// - literal minus accumulator into accumulator, C DC Z
// - accumulator xor literal into accumulator, Z only
// - register minus accumulator, C DC Z
// - destination bit picks accumulator or register
// - accumulator xor register routed, Z only
// - swap register nibbles, routed, no flags
`timescale 1ns/1ns
module mex_exec_unit #(
   parameter int STACK_D = mex_pkg::STACK_D
) (
   input  wire logic                               clk_i,
   input  wire logic                               arst_n_i,
   input  wire logic                               instr_valid_i,
   input  wire mex_pkg::mex_instr_s                instr_i,
   output logic                                    instr_ready_o,
   output logic      [mex_pkg::ADDR_W-1:0]         reg_raddr_o,
   input  wire logic [mex_pkg::DATA_W-1:0]         reg_rdata_i,
   output mex_pkg::mex_wr_s                        reg_wr_o,
   input  wire logic                               push_valid_i,
   input  wire logic [mex_pkg::PTR_W-1:0]          push_addr_i,
   output logic                                    fetch_load_o,
   output logic      [mex_pkg::PTR_W-1:0]          fetch_pointer_o,
   output logic      [mex_pkg::DATA_W-1:0]         acc_o,
   output mex_pkg::mex_flags_s                     flags_o,
   output logic                                    watchdog_clear_o,
   output logic                                    prescaler_clear_o,
   output logic                                    osc_stop_o,
   input  wire logic                               wake_i
);

   localparam int SP_W = $clog2(STACK_D);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   mex_pkg::mex_state_e                state_reg, state_next;
   logic [mex_pkg::DATA_W-1:0]         acc_reg, acc_next;
   mex_pkg::mex_flags_s                flags_reg, flags_next;
   mex_pkg::mex_wr_s                   wr_reg, wr_next;
   logic [mex_pkg::PTR_W-1:0]          fptr_reg;
   logic                               fload_reg;
   logic                               wdog_clr_reg;
   logic [SP_W-1:0]                    sp_reg;
   logic [mex_pkg::PTR_W-1:0]          stack_mem [STACK_D];

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire        take      = instr_valid_i & instr_ready_o;
   wire        is_ret    = take & (instr_i.op == mex_pkg::MEX_OP_RETURN);
   wire        is_halt   = take & (instr_i.op == mex_pkg::MEX_OP_HALT);
   wire        is_sublit = take & (instr_i.op == mex_pkg::MEX_OP_SUB_LIT);
   wire        is_xorlit = take & (instr_i.op == mex_pkg::MEX_OP_XOR_LIT);
   wire        is_subreg = take & (instr_i.op == mex_pkg::MEX_OP_SUB_REG);
   wire        is_xorreg = take & (instr_i.op == mex_pkg::MEX_OP_XOR_REG);
   wire        is_nibex  = take & (instr_i.op == mex_pkg::MEX_OP_NIB_EXCH);
   wire        is_regop  = is_subreg | is_xorreg | is_nibex;
   wire        is_sub    = is_sublit | is_subreg;
   wire        is_xor    = is_xorlit | is_xorreg;

   // ------------------------------------------------------------
   // operand selection and arithmetic
   // ------------------------------------------------------------
   wire [mex_pkg::DATA_W-1:0] opnd     = is_sublit | is_xorlit ? instr_i.literal : reg_rdata_i;
   wire [mex_pkg::DATA_W-1:0] xor_res  = acc_reg ^ opnd;
   wire [mex_pkg::DATA_W-1:0] nib_res  = {reg_rdata_i[mex_pkg::NIB_W-1:0],
                                          reg_rdata_i[mex_pkg::DATA_W-1:mex_pkg::NIB_W]};
   wire [mex_pkg::DATA_W-1:0] sub_res;
   wire                       sub_c;
   wire                       sub_dc;
   wire                       sub_z;
   wire [mex_pkg::DATA_W-1:0] result   = is_sub ? sub_res : (is_xor ? xor_res : nib_res);
   wire                       to_reg   = is_regop & (instr_i.dest == mex_pkg::DEST_REG);
   wire                       to_acc   = is_sublit | is_xorlit
                                       | (is_regop & (instr_i.dest == mex_pkg::DEST_ACC));
   wire [SP_W-1:0]            sp_dec   = sp_reg - {{(SP_W-1){1'b0}}, 1'b1};

   // literal or register minus accumulator
   mex_sub_unit #(
      .W  (mex_pkg::DATA_W),
      .NW (mex_pkg::NIB_W)
   ) u_sub (
      .minuend_i    (opnd),
      .subtrahend_i (acc_reg),
      .diff_o       (sub_res),
      .carry_o      (sub_c),
      .half_o       (sub_dc),
      .zero_o       (sub_z)
   );

   assign reg_raddr_o = instr_i.reg_addr;

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   // sequencing: return blocks one cycle, halt waits for wake
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         mex_pkg::MEX_ST_RUN: begin
            if (is_ret) begin
               state_next = mex_pkg::MEX_ST_RET2;
            end else if (is_halt) begin
               state_next = mex_pkg::MEX_ST_HALT;
            end
         end
         mex_pkg::MEX_ST_RET2: begin
            state_next = mex_pkg::MEX_ST_RUN;
         end
         mex_pkg::MEX_ST_HALT: begin
            if (wake_i) begin
               state_next = mex_pkg::MEX_ST_RUN;
            end
         end
         default: begin
            state_next = mex_pkg::MEX_ST_RUN;
         end
      endcase
   end

   // accumulator, flags and write-back
   always_comb begin
      acc_next   = acc_reg;
      flags_next = flags_reg;
      wr_next    = '{we: to_reg, addr: instr_i.reg_addr, data: result};
      if (to_acc) begin
         acc_next = result;
      end
      if (is_sub) begin
         flags_next.carry              = sub_c;
         flags_next.half_arith_out_bit = sub_dc;
         flags_next.zero               = sub_z;
      end else if (is_xor) begin
         flags_next.zero = (xor_res == '0);
      end
      if (is_halt) begin
         flags_next.powerdown_flag_n = 1'b0;
         flags_next.timeout_flag_n   = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= mex_pkg::MEX_ST_RUN;
         acc_reg   <= mex_pkg::ACC_RST;
         flags_reg <= '{carry: 1'b0, half_arith_out_bit: 1'b0, zero: 1'b0,
                        timeout_flag_n: mex_pkg::TO_N_RST,
                        powerdown_flag_n: mex_pkg::PD_N_RST};
         wr_reg    <= '0;
      end else begin
         state_reg <= state_next;
         acc_reg   <= acc_next;
         flags_reg <= flags_next;
         wr_reg    <= wr_next;
      end
   end

   // return stack pointer and fetch pointer load
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sp_reg       <= '0;
         fptr_reg     <= '0;
         fload_reg    <= 1'b0;
         wdog_clr_reg <= 1'b0;
      end else begin
         fload_reg    <= is_ret;
         wdog_clr_reg <= is_halt;
         if (is_ret) begin
            fptr_reg <= stack_mem[sp_dec];
            sp_reg   <= sp_dec;
         end else if (push_valid_i) begin
            sp_reg   <= sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // stack storage, circular like the real return stack
   always_ff @(posedge clk_i) begin
      if (push_valid_i && !is_ret) begin
         stack_mem[sp_reg] <= push_addr_i;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign instr_ready_o     = (state_reg == mex_pkg::MEX_ST_RUN);
   assign acc_o             = acc_reg;
   assign flags_o           = flags_reg;
   assign reg_wr_o          = wr_reg;
   assign fetch_load_o      = fload_reg;
   assign fetch_pointer_o   = fptr_reg;
   assign watchdog_clear_o  = wdog_clr_reg;
   assign prescaler_clear_o = wdog_clr_reg;
   assign osc_stop_o        = (state_reg == mex_pkg::MEX_ST_HALT);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_ret_flags_kept: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_ret |=> (flags_o == $past(flags_o)) && fetch_load_o)
      else $error("return changed flags or did not load fetch pointer");

   a_ret_two_cycles: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_ret |=> !instr_ready_o ##1 instr_ready_o)
      else $error("return did not hold exactly one idle cycle");

   a_halt_wdog_clr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_halt |=> watchdog_clear_o && prescaler_clear_o)
      else $error("halt did not clear watchdog and prescaler");

   a_halt_status: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_halt |=> !flags_o.powerdown_flag_n && flags_o.timeout_flag_n
                  && flags_o.carry == $past(flags_o.carry)
                  && flags_o.zero == $past(flags_o.zero))
      else $error("halt status flags wrong");

   a_halt_osc_stop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_halt ##1 !wake_i |=> osc_stop_o && !instr_ready_o)
      else $error("halt did not stop the oscillator");

   a_sub_lit_value: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_sublit |=> acc_o == 8'(($past(instr_i.literal)) - $past(acc_o))
                    && flags_o.carry == ($past(instr_i.literal) >= $past(acc_o)))
      else $error("literal subtract result or carry wrong");

   a_xor_lit_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_xorlit |=> acc_o == ($past(acc_o) ^ $past(instr_i.literal))
                    && flags_o.carry == $past(flags_o.carry)
                    && flags_o.zero == (acc_o == 8'h00))
      else $error("literal xor wrong");

   a_sub_reg_half: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_subreg |=> flags_o.half_arith_out_bit ==
                    ($past(reg_rdata_i[3:0]) >= $past(acc_o[3:0])))
      else $error("register subtract half carry wrong");

   a_dest_route: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_regop && instr_i.dest |=> reg_wr_o.we && acc_o == $past(acc_o))
      else $error("register destination not honoured");

   a_xor_reg_value: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_xorreg && !instr_i.dest |=> acc_o == ($past(acc_o) ^ $past(reg_rdata_i))
                                     && !reg_wr_o.we)
      else $error("register xor to accumulator wrong");

   a_nib_exch: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      is_nibex |=> reg_wr_o.data == {$past(reg_rdata_i[3:0]), $past(reg_rdata_i[7:4])}
                   && flags_o == $past(flags_o))
      else $error("nibble exchange wrong");

endmodule : mex_exec_unit

//--- verilog/mex_pkg.sv
package mex_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int DATA_W     = 8;
   localparam int ADDR_W     = 7;
   localparam int PTR_W      = 13;
   localparam int NIB_W      = 4;
   localparam int STACK_D    = 8;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] ACC_RST      = 8'h00;
   localparam logic [DATA_W-1:0] WDOG_CLR_VAL = 8'h00;
   localparam logic              TO_N_RST     = 1'b1;
   localparam logic              PD_N_RST     = 1'b1;

   // ------------------------------------------------------------
   // destination bit encoding
   // ------------------------------------------------------------
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_REG = 1'b1;

   // ------------------------------------------------------------
   // operations and states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MEX_OP_NONE,
      MEX_OP_RETURN,
      MEX_OP_HALT,
      MEX_OP_SUB_LIT,
      MEX_OP_XOR_LIT,
      MEX_OP_SUB_REG,
      MEX_OP_XOR_REG,
      MEX_OP_NIB_EXCH
   } mex_op_e;

   typedef enum logic [1:0] {
      MEX_ST_RUN,
      MEX_ST_RET2,
      MEX_ST_HALT
   } mex_state_e;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      mex_op_e                op;
      logic [ADDR_W-1:0]      reg_addr;
      logic                   dest;
      logic [DATA_W-1:0]      literal;
   } mex_instr_s;

   typedef struct packed {
      logic carry;
      logic half_arith_out_bit;
      logic zero;
      logic timeout_flag_n;
      logic powerdown_flag_n;
   } mex_flags_s;

   typedef struct packed {
      logic                   we;
      logic [ADDR_W-1:0]      addr;
      logic [DATA_W-1:0]      data;
   } mex_wr_s;

endpackage : mex_pkg

//--- verilog/mex_sub_unit.sv
`timescale 1ns/1ns
// two's complement subtract with no-borrow carries
module mex_sub_unit #(
   parameter int W  = 8,
   parameter int NW = 4
) (
   input  wire logic [W-1:0] minuend_i,
   input  wire logic [W-1:0] subtrahend_i,
   output logic      [W-1:0] diff_o,
   output logic              carry_o,
   output logic              half_o,
   output logic              zero_o
);

   // ------------------------------------------------------------
   // adder on inverted subtrahend plus one
   // ------------------------------------------------------------
   logic [W:0]  full_sum;
   logic [NW:0] low_sum;

   // carry out means no borrow
   assign full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + {{W{1'b0}}, 1'b1};
   assign low_sum  = {1'b0, minuend_i[NW-1:0]} + {1'b0, ~subtrahend_i[NW-1:0]}
                     + {{NW{1'b0}}, 1'b1};
   assign diff_o   = full_sum[W-1:0];
   assign carry_o  = full_sum[W];
   assign half_o   = low_sum[NW];
   assign zero_o   = (diff_o == '0);

endmodule : mex_sub_unit

//--- verification/mex_dmem_model.sv
`timescale 1ns/1ns
// data memory seen by the execution unit: combinational read, clocked write
module mex_dmem_model (
   input  wire logic                       clk_i,
   input  wire logic [mex_pkg::ADDR_W-1:0] raddr_i,
   output logic      [mex_pkg::DATA_W-1:0] rdata_o,
   input  wire mex_pkg::mex_wr_s           wr_i
);
   logic [mex_pkg::DATA_W-1:0] mem [128];

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // fixed fill pattern, mirrored by the bench
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'(i * 37 + 19);
      end
   end

   // read data must be valid in the same cycle as the address
   assign rdata_o = mem[raddr_i];

   // write-back lands on the edge after the pulse is seen
   always @(posedge clk_i) begin
      if (wr_i.we === 1'b1) begin
         mem[wr_i.addr] <= wr_i.data;
      end
   end
endmodule : mex_dmem_model

//--- verification/tb.sv
`timescale 1ns/1ns
module tb;
   typedef struct packed {
      logic [7:0] acc; logic [4:0] fl; logic we; logic [6:0] wa; logic [7:0] wd;
      logic ld; logic [12:0] fp; logic [1:0] clr; logic stop;
   } mex_note_s;

   logic                clk_i = 1'b0;
   logic                arst_n_i = 1'b0;
   logic                instr_valid = 1'b0;
   mex_pkg::mex_instr_s instr = '0;
   logic                push_valid = 1'b0;
   logic [12:0]         push_addr = 13'h0000;
   logic                wake = 1'b0;
   logic                instr_ready_o, fetch_load_o, watchdog_clear_o, prescaler_clear_o;
   logic                osc_stop_o, took = 1'b0;
   logic [6:0]          raddr;
   logic [7:0]          rdata, acc_o, acc_s = 8'h00, shm [128];
   logic [12:0]         fetch_pointer_o, fp_s = 13'h0000;
   logic [4:0]          fl_s = 5'h03;
   logic [31:0]         rnd = 32'h7d2ceb7e;
   mex_pkg::mex_wr_s    reg_wr_o;
   mex_pkg::mex_flags_s flags_o;
   mex_note_s           notes[$], nt, got;
   logic [12:0]         stk[$];
   int                  err_total = 0;
   int                  tests_run = 0;

   always #4 clk_i = ~clk_i;

   mex_exec_unit i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid),
      .instr_i(instr), .instr_ready_o(instr_ready_o), .reg_raddr_o(raddr),
      .reg_rdata_i(rdata), .reg_wr_o(reg_wr_o), .push_valid_i(push_valid),
      .push_addr_i(push_addr), .fetch_load_o(fetch_load_o), .fetch_pointer_o(fetch_pointer_o),
      .acc_o(acc_o), .flags_o(flags_o), .watchdog_clear_o(watchdog_clear_o),
      .prescaler_clear_o(prescaler_clear_o), .osc_stop_o(osc_stop_o), .wake_i(wake));
   mex_dmem_model i_mem (.clk_i(clk_i), .raddr_i(raddr), .rdata_o(rdata), .wr_i(reg_wr_o));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      if (err_total == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   // offer one instruction, note its expected outcome, wait until it is taken
   task automatic issue(input mex_pkg::mex_op_e op, input logic [6:0] a, input logic d,
                        input logic [7:0] k);
      mex_note_s  n;
      logic [7:0] x, r;
      int         w;
      @(posedge clk_i);
      instr_valid <= 1'b1;
      instr <= '{op: op, reg_addr: a, dest: d, literal: k};
      n = '{acc: acc_s, fl: fl_s, fp: fp_s, default: '0};
      x = (op == mex_pkg::MEX_OP_SUB_LIT || op == mex_pkg::MEX_OP_XOR_LIT) ? k : shm[a];
      r = x - acc_s;
      if (op == mex_pkg::MEX_OP_SUB_LIT || op == mex_pkg::MEX_OP_SUB_REG) begin
         n.fl[4:2] = {x >= acc_s, x[3:0] >= acc_s[3:0], r == 8'h00};
      end else if (op == mex_pkg::MEX_OP_XOR_LIT || op == mex_pkg::MEX_OP_XOR_REG) begin
         r = x ^ acc_s;
         n.fl[2] = (r == 8'h00);
      end else if (op == mex_pkg::MEX_OP_NIB_EXCH) begin
         r = {x[3:0], x[7:4]};
      end
      if (op == mex_pkg::MEX_OP_RETURN) begin
         n.ld = 1'b1;
         n.fp = stk.pop_back();
         fp_s = n.fp;
      end else if (op == mex_pkg::MEX_OP_HALT) begin
         n.fl[1:0] = 2'b10;
         n.clr = 2'b11;
         n.stop = 1'b1;
      end else if (d && op >= mex_pkg::MEX_OP_SUB_REG) begin
         n.we = 1'b1; n.wa = a; n.wd = r; shm[a] = r;
      end else begin
         n.acc = r;
      end
      acc_s = n.acc;
      fl_s = n.fl;
      @(negedge clk_i);
      for (w = 0; w < 50 && instr_ready_o !== 1'b1; w++) begin
         @(negedge clk_i);
      end
      notes.push_back(n);
      if (n.we) begin
         @(posedge clk_i);
         instr_valid <= 1'b0;
      end
   endtask : issue

   task automatic idle();
      @(posedge clk_i);
      instr_valid <= 1'b0;
   endtask : idle

   task automatic push(input logic [12:0] a);
      @(posedge clk_i);
      push_valid <= 1'b1;
      push_addr <= a;
      stk.push_back(a);
      @(posedge clk_i);
      push_valid <= 1'b0;
   endtask : push

   // ------------------------------------------------------------
   // output watcher
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      took <= arst_n_i && instr_valid && instr_ready_o && instr.op != mex_pkg::MEX_OP_NONE;
   end

   // compare the oldest note whenever a taken instruction has answered
   always @(negedge clk_i) begin
      if (took) begin
         nt = (notes.size() > 0) ? notes.pop_front() : '1;
         got = {acc_o, flags_o, reg_wr_o.we, reg_wr_o.we ? reg_wr_o.addr : 7'h00,
                reg_wr_o.we ? reg_wr_o.data : 8'h00, fetch_load_o, fetch_pointer_o,
                watchdog_clear_o, prescaler_clear_o, osc_stop_o};
         chk(got[45:33], nt[45:33]);
         chk(got[32:17], nt[32:17]);
         chk(got[16:0], nt[16:0]);
      end else if (arst_n_i) begin
         chk({reg_wr_o.we, fetch_load_o, watchdog_clear_o, prescaler_clear_o}, 4'h0);
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      for (int i = 0; i < 128; i++) begin
         shm[i] = 8'(i * 37 + 19);
      end
      repeat (6) @(posedge clk_i);
      arst_n_i <= 1'b1;
      issue(mex_pkg::MEX_OP_SUB_LIT, 7'h00, 1'b0, 8'h00);
      issue(mex_pkg::MEX_OP_XOR_LIT, 7'h00, 1'b1, 8'h01);
      issue(mex_pkg::MEX_OP_SUB_LIT, 7'h00, 1'b0, 8'h00);
      for (int j = 0; j < 6; j++) begin
         issue(mex_pkg::mex_op_e'(j % 3 + 5), 7'h7f, j[0], 8'h00);
      end
      for (int j = 0; j < 60; j++) begin
         rnd = lfsr_next(rnd);
         issue(mex_pkg::mex_op_e'(3 + rnd[31:8] % 5), rnd[6:0], rnd[7], rnd[15:8]);
      end
      idle();
      for (int j = 0; j < 3; j++) begin
         rnd = lfsr_next(rnd);
         push(rnd[12:0]);
      end
      issue(mex_pkg::MEX_OP_RETURN, 7'h00, 1'b0, 8'h00);
      issue(mex_pkg::MEX_OP_RETURN, 7'h00, 1'b0, 8'h00);
      issue(mex_pkg::MEX_OP_XOR_LIT, 7'h00, 1'b0, 8'h5a);
      issue(mex_pkg::MEX_OP_HALT, 7'h00, 1'b0, 8'h00);
      idle();
      repeat (4) @(posedge clk_i);
      chk(osc_stop_o, 1'b1);
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      issue(mex_pkg::MEX_OP_SUB_REG, 7'h12, 1'b0, 8'h00);
      idle();
      repeat (3) @(posedge clk_i);
      chk(notes.size(), 0);
      tally_and_finish();
   end

   // cut a hang short
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      tally_and_finish();
   end
endmodule : tb
